// *** rtl/vpi_pkg.sv ***
/*
  Package for the vectored priority interrupt slice: micro-op codes,
  reset values, widths and the cascade output carrier.
  Assumes a single sys_clk domain shared by all cascaded slices.
*/
package vpi_pkg;

  localparam int unsigned VPI_LEVELS = 8;
  localparam int unsigned VPI_VW     = 3;

  typedef enum logic [3:0] {
    VPI_OP_MCLR      = 4'h0,
    VPI_OP_CLR_ALL   = 4'h1,
    VPI_OP_CLR_MBUS  = 4'h2,
    VPI_OP_CLR_MASK  = 4'h3,
    VPI_OP_CLR_LAST  = 4'h4,
    VPI_OP_RD_VEC    = 4'h5,
    VPI_OP_RD_STAT   = 4'h6,
    VPI_OP_RD_MASK   = 4'h7,
    VPI_OP_SET_MASK  = 4'h8,
    VPI_OP_LD_STAT   = 4'h9,
    VPI_OP_BCLR_MASK = 4'ha,
    VPI_OP_BSET_MASK = 4'hb,
    VPI_OP_CLR_MREG  = 4'hc,
    VPI_OP_DIS_REQ   = 4'hd,
    VPI_OP_LD_MASK   = 4'he,
    VPI_OP_EN_REQ    = 4'hf
  } vpi_op_t;

  localparam logic [7:0] VPI_MASK_RST   = 8'h00;
  localparam logic [7:0] VPI_MASK_ALL   = 8'hff;
  localparam logic [2:0] VPI_STAT_RST   = 3'h0;
  localparam logic [2:0] VPI_HOLD_RST   = 3'h0;
  localparam logic [2:0] VPI_VEC_TOP    = 3'h7;
  localparam logic       VPI_LGE_RST_N  = 1'b1;
  localparam logic       VPI_REQEN_RST  = 1'b1;
  localparam logic [7:0] VPI_SYNC_RST   = 8'hff;
  localparam logic [7:0] VPI_IRQ_RST    = 8'h00;
  localparam logic       VPI_BYP_RST    = 1'b0;
  localparam logic       VPI_VCE_RST    = 1'b0;
  localparam logic       VPI_OVF_RST_N  = 1'b1;

  typedef struct packed {
    logic group_signal_out;
    logic group_advance_send;
    logic ripple_disable_n;
    logic parallel_disable_n;
  } vpi_casc_t;

endpackage

// *** rtl/vpi_slice.sv ***
/*
  One cascadable eight-level vectored priority interrupt slice.
  Assumes: micro_op_field, instr_enable_n and the cascade inputs come
  from logic on sys_clk; interrupt inputs and latch bypass are pins.
  Three-state buses are split into in/out/enable; the bench resolves them.
*/
`timescale 1ns/1ps
`default_nettype none
module vpi_slice
  import vpi_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] int_in_n,
  input  wire logic       latch_bypass,
  input  wire logic [3:0] micro_op_field,
  input  wire logic       instr_enable_n,
  input  wire logic [7:0] mask_bus_in,
  output logic      [7:0] mask_bus_out,
  output logic            mask_bus_oe,
  input  wire logic [2:0] status_bus_in,
  output logic      [2:0] status_bus_out,
  output logic            status_bus_oe,
  output logic      [2:0] vector_out,
  output logic            vector_oe,
  output logic            int_request,
  input  wire logic       interrupt_disable_n,
  input  wire logic       group_enable_in,
  input  wire logic       group_advance_receive,
  output logic            status_overflow_n,
  output var vpi_casc_t   cascade_out
);

  // ********************************
  // Input synchronisers
  // ********************************
  logic [7:0] int_s1_r;
  logic [7:0] int_s2_r;
  logic       byp_s1_r;
  logic       byp_s2_r;

  // Pins are asynchronous to sys_clk; only the second stage feeds logic
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_s1_r <= VPI_SYNC_RST;
      int_s2_r <= VPI_SYNC_RST;
    end else begin
      int_s1_r <= int_in_n;
      int_s2_r <= int_s1_r;
    end
  end

  // Bypass is a strap pin, synchronised the same way as the inputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_s1_r <= VPI_BYP_RST;
      byp_s2_r <= VPI_BYP_RST;
    end else begin
      byp_s1_r <= latch_bypass;
      byp_s2_r <= byp_s1_r;
    end
  end

  // ********************************
  // Micro-op decode
  // ********************************
  // One strobe per code; each strobe already carries the enable, so a
  // shared field driven while the enable is high never acts here
  function automatic logic vpi_op_hit(input logic go, input logic [3:0] f,
                                      input vpi_op_t c);
    return go && (f == c);
  endfunction

  logic    [3:0] op_code;
  logic          op_go;
  logic          op_mclr;
  logic          op_clrall;
  logic          op_clrmbus;
  logic          op_clrmask;
  logic          op_clrlast;
  logic          op_rdvec;
  logic          op_rdstat;
  logic          op_rdmask;
  logic          op_setmask;
  logic          op_ldstat;
  logic          op_bclrmask;
  logic          op_bsetmask;
  logic          op_clrmreg;
  logic          op_disreq;
  logic          op_ldmask;
  logic          op_enreq;

  assign op_code     = micro_op_field;
  assign op_go       = ~instr_enable_n;
  assign op_mclr     = vpi_op_hit(op_go, op_code, VPI_OP_MCLR);
  assign op_clrall   = vpi_op_hit(op_go, op_code, VPI_OP_CLR_ALL);
  assign op_clrmbus  = vpi_op_hit(op_go, op_code, VPI_OP_CLR_MBUS);
  assign op_clrmask  = vpi_op_hit(op_go, op_code, VPI_OP_CLR_MASK);
  assign op_clrlast  = vpi_op_hit(op_go, op_code, VPI_OP_CLR_LAST);
  assign op_rdvec    = vpi_op_hit(op_go, op_code, VPI_OP_RD_VEC);
  assign op_rdstat   = vpi_op_hit(op_go, op_code, VPI_OP_RD_STAT);
  assign op_rdmask   = vpi_op_hit(op_go, op_code, VPI_OP_RD_MASK);
  assign op_setmask  = vpi_op_hit(op_go, op_code, VPI_OP_SET_MASK);
  assign op_ldstat   = vpi_op_hit(op_go, op_code, VPI_OP_LD_STAT);
  assign op_bclrmask = vpi_op_hit(op_go, op_code, VPI_OP_BCLR_MASK);
  assign op_bsetmask = vpi_op_hit(op_go, op_code, VPI_OP_BSET_MASK);
  assign op_clrmreg  = vpi_op_hit(op_go, op_code, VPI_OP_CLR_MREG);
  assign op_disreq   = vpi_op_hit(op_go, op_code, VPI_OP_DIS_REQ);
  assign op_ldmask   = vpi_op_hit(op_go, op_code, VPI_OP_LD_MASK);
  assign op_enreq    = vpi_op_hit(op_go, op_code, VPI_OP_EN_REQ);

  // ********************************
  // State
  // ********************************
  logic [7:0] latch_r;
  logic [7:0] latch_nxt;
  logic [7:0] ireg_r;
  logic [7:0] ireg_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [2:0] status_r;
  logic [2:0] status_nxt;
  logic [2:0] hold_r;
  logic [2:0] hold_nxt;
  logic       lge_n_r;
  logic       lge_n_nxt;
  logic       vce_r;
  logic       vce_nxt;
  logic       ovf_n_r;
  logic       ovf_n_nxt;
  logic       reqen_r;
  logic       reqen_nxt;

  // ********************************
  // Detect, encode, compare
  // ********************************
  // Higher index is higher priority; the loop keeps the last hit
  function automatic logic [2:0] vpi_prio_enc(input logic [7:0] req);
    logic [2:0] v;
    v = 3'h0;
    for (int i = 0; i < VPI_LEVELS; i++) begin
      if (req[i]) begin
        v = i[2:0];
      end
    end
    return v;
  endfunction

  // Turns a held vector back into the one level it names
  function automatic logic [7:0] vpi_onehot(input logic [2:0] v);
    return 8'h01 << v;
  endfunction

  logic [7:0] pend;
  logic       any_pend;
  logic [2:0] vec;
  logic       vec_ge;
  logic       req;
  logic       vec_top;

  assign pend     = ireg_r & ~mask_r;
  assign any_pend = |pend;
  assign vec      = vpi_prio_enc(pend);
  assign vec_ge   = (vec >= status_r);
  assign vec_top  = (vec == VPI_VEC_TOP);

  // ********************************
  // Request and own read
  // ********************************
  // Disable low kills the request outright
  assign req = any_pend && vec_ge && reqen_r && interrupt_disable_n;

  // Only the slice that raised the request takes the read as its own
  logic       rd_own;
  logic       own_top;
  logic [2:0] vec_inc;

  assign rd_own  = op_rdvec && req;
  assign own_top = rd_own && vec_top;
  assign vec_inc = 3'(vec + 3'h1);

  // ********************************
  // Clear control
  // ********************************
  logic [7:0] clr;
  logic [7:0] clr_last;

  // Clear-last reaches only the level this slice itself handed out
  assign clr_last = vce_r ? vpi_onehot(hold_r) : 8'h00;
  // Clearing by mask register takes nothing from the bus
  assign clr      = (op_mclr || op_clrall) ? 8'hff :
                    op_clrmbus             ? mask_bus_in :
                    op_clrmask             ? mask_r :
                    op_clrlast             ? clr_last :
                    8'h00;

  // ********************************
  // Latches and interrupt register
  // ********************************
  logic [7:0] in_act;
  logic [7:0] lat_view;

  assign in_act    = ~int_s2_r;
  // Transparent latches hold nothing, so no stale level survives a switch
  // back to pulse catching. A new low wins over a clear in the same cycle.
  assign latch_nxt = byp_s2_r ? VPI_IRQ_RST : ((latch_r & ~clr) | in_act);
  // The register sees the latch as it stands after this cycle's clear;
  // reading latch_r here would re-set a bit in the cycle it is cleared
  assign lat_view  = byp_s2_r ? in_act : latch_nxt;
  assign ireg_nxt  = (ireg_r & ~clr) | lat_view;

  // ********************************
  // Mask, status and flag next state
  // ********************************
  // Set mask inhibits every level; clear mask leaves status and enable
  assign mask_nxt  = (op_mclr || op_clrmreg) ? VPI_MASK_RST :
                     op_setmask              ? VPI_MASK_ALL :
                     op_bclrmask             ? (mask_r & ~mask_bus_in) :
                     op_bsetmask             ? (mask_r | mask_bus_in) :
                     op_ldmask               ? mask_bus_in :
                     mask_r;
  // Master clear sets request enable so the system starts interrupt driven
  assign reqen_nxt = (op_mclr || op_enreq) ? 1'b1 :
                     op_disreq             ? 1'b0 :
                     reqen_r;

  // ********************************
  // Status, hold and group flags
  // ********************************
  assign status_nxt = op_mclr   ? VPI_STAT_RST :
                      op_ldstat ? status_bus_in :
                      rd_own    ? vec_inc :
                      status_r;
  // Master clear leaves the hold register alone; clear enable guards it
  assign hold_nxt   = rd_own ? vec : hold_r;
  assign vce_nxt    = op_mclr ? VPI_VCE_RST :
                      op_rdvec ? rd_own : vce_r;
  // Overflow marks the status wrap from seven back to zero
  assign ovf_n_nxt  = (op_mclr || op_ldstat) ? VPI_OVF_RST_N :
                      own_top ? 1'b0 : ovf_n_r;
  // Grounded receive makes the bottom slice the enabled group on clear
  assign lge_n_nxt  = op_mclr   ? group_advance_receive :
                      op_ldstat ? group_enable_in :
                      (op_rdvec && !group_advance_receive) ? 1'b0 :
                      own_top ? 1'b1 :
                      lge_n_r;

  // ********************************
  // Registers, rising edge
  // ********************************
  // Interrupt path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= VPI_IRQ_RST;
      ireg_r  <= VPI_IRQ_RST;
    end else begin
      latch_r <= latch_nxt;
      ireg_r  <= ireg_nxt;
    end
  end

  // Mask, status and hold registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r   <= VPI_MASK_RST;
      status_r <= VPI_STAT_RST;
      hold_r   <= VPI_HOLD_RST;
    end else begin
      mask_r   <= mask_nxt;
      status_r <= status_nxt;
      hold_r   <= hold_nxt;
    end
  end

  // Single-bit flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lge_n_r <= VPI_LGE_RST_N;
      vce_r   <= VPI_VCE_RST;
      ovf_n_r <= VPI_OVF_RST_N;
      reqen_r <= VPI_REQEN_RST;
    end else begin
      lge_n_r <= lge_n_nxt;
      vce_r   <= vce_nxt;
      ovf_n_r <= ovf_n_nxt;
      reqen_r <= reqen_nxt;
    end
  end

  // ********************************
  // Outputs and cascade
  // ********************************
  // Buses leave as value plus enable; the three-state drivers sit outside
  assign int_request    = req;
  assign mask_bus_out   = mask_r;
  assign mask_bus_oe    = op_rdmask;
  assign status_bus_out = status_r;
  assign status_bus_oe  = op_rdstat;
  assign vector_out     = vec;
  assign vector_oe      = op_rdvec;
  assign status_overflow_n = ovf_n_r;

  assign cascade_out.group_signal_out   = lge_n_r;
  assign cascade_out.group_advance_send = ~own_top;
  assign cascade_out.ripple_disable_n   =
    interrupt_disable_n && lge_n_r && !req;
  assign cascade_out.parallel_disable_n = lge_n_r && !req;

endmodule
`default_nettype wire

// *** test/vpi_slice_checker.sv ***
/* Port assertions for one interrupt slice, bound into every vpi_slice.
   Assumes one sys_clk domain and an asynchronous active-low rst_n. */
`timescale 1ns/1ps
`default_nettype none
module vpi_slice_checker
  import vpi_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [3:0] micro_op_field,
  input wire logic       instr_enable_n,
  input wire logic [7:0] mask_bus_out,
  input wire logic       mask_bus_oe,
  input wire logic [2:0] status_bus_out,
  input wire logic       status_bus_oe,
  input wire logic [2:0] vector_out,
  input wire logic       vector_oe,
  input wire logic       int_request,
  input wire logic       interrupt_disable_n,
  input wire logic       group_enable_in,
  input wire logic       status_overflow_n,
  input wire vpi_casc_t  cascade_out
);
  wire logic en  = !instr_enable_n;
  wire logic rv  = en && micro_op_field == VPI_OP_RD_VEC;
  wire logic top = rv && int_request && vector_out == VPI_VEC_TOP;
  wire logic ld  = en && micro_op_field == VPI_OP_LD_STAT;
  wire logic mc  = en && micro_op_field == VPI_OP_MCLR;
  wire logic gs  = cascade_out.group_signal_out;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ****************
  // Port relations
  // ****************
  vec_drive_a: assert property (vector_oe == rv)
    else $error("vector enable wrong");
  mask_drive_a: assert property (mask_bus_oe == (en && micro_op_field == VPI_OP_RD_MASK))
    else $error("mask enable wrong");
  stat_drive_a: assert property (status_bus_oe == (en && micro_op_field == VPI_OP_RD_STAT))
    else $error("status enable wrong");
  req_gate_a: assert property (int_request |-> vector_out >= status_bus_out && interrupt_disable_n)
    else $error("request below threshold");
  stat_inc_a: assert property (rv && int_request |=> status_bus_out == 3'($past(vector_out) + 3'h1))
    else $error("status not vector plus one");
  top_send_a: assert property (top |-> !cascade_out.group_advance_send)
    else $error("advance send missing");
  ovf_set_a: assert property (top |=> !status_overflow_n)
    else $error("overflow not set");
  // Overflow is sticky: only new status or a master clear may lift it
  ovf_hold_a: assert property (!status_overflow_n && !ld && !mc |=> !status_overflow_n)
    else $error("overflow lifted early");
  grp_load_a: assert property (ld |=> gs == $past(group_enable_in))
    else $error("group flop not loaded");
  ripple_dis_a: assert property (cascade_out.ripple_disable_n ==
    !(!interrupt_disable_n || !gs || int_request)) else $error("ripple disable wrong");
  par_dis_a: assert property (cascade_out.parallel_disable_n == !(!gs || int_request))
    else $error("parallel disable wrong");
  mclr_regs_a: assert property (mc |=> mask_bus_out == VPI_MASK_RST &&
    status_bus_out == VPI_STAT_RST && status_overflow_n) else $error("clear incomplete");
endmodule
bind vpi_slice vpi_slice_checker u_vpi_slice_checker (.sys_clk, .rst_n, .micro_op_field,
  .instr_enable_n, .mask_bus_out, .mask_bus_oe, .status_bus_out, .status_bus_oe, .vector_out,
  .vector_oe, .int_request, .interrupt_disable_n, .group_enable_in, .status_overflow_n,
  .cascade_out);
`default_nettype wire

// *** test/vpi_ctl_model.sv ***
/* Integrator side of a lone slice: cascade inputs and the disable loop.
   Assumes one slice, which is both the lowest and the highest group. */
`timescale 1ns/1ps
`default_nettype none
module vpi_ctl_model (
  input  wire logic status_overflow_n,
  input  wire logic parallel_disable_n,
  output logic      interrupt_disable_n,
  output logic      group_enable_in,
  output logic      group_advance_receive,
  output logic      lower_groups_disable_n
);
  // ****************
  // Cascade wiring
  // ****************
  // Top group feeds overflow back so reading vector seven stops requests
  assign interrupt_disable_n   = status_overflow_n;
  assign group_advance_receive = 1'b0;
  assign group_enable_in       = 1'b0;
  // Lookahead fan-out: any group's parallel disable stops all lower groups
  assign lower_groups_disable_n = parallel_disable_n;
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
/* Self-checking bench: acts as control unit for one slice.
   Assumes vpi_ctl_model closes the cascade loop of a lone slice. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import vpi_pkg::*;
();
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        latch_bypass = 1'b0;
  logic        instr_enable_n = 1'b1;
  logic [7:0]  int_in_n = 8'hff;
  logic [7:0]  mb = 8'h00;
  logic [3:0]  micro_op_field = 4'h0;
  logic [2:0]  sb = 3'h0;
  logic [31:0] seed = 32'hdf311c1d;
  logic [7:0]  m;
  logic [7:0]  q[$];
  int          fails = 0;
  int          tests_run = 0;
  wire logic [7:0] mask_bus_out, mask_bus_in, rd_got;
  wire logic [2:0] status_bus_out, status_bus_in, vector_out;
  wire logic mask_bus_oe, status_bus_oe, vector_oe, int_request, status_overflow_n;
  wire logic interrupt_disable_n, group_enable_in, group_advance_receive;
  wire vpi_casc_t cascade_out;
  // Shared buses: the slice wins while it drives
  assign mask_bus_in   = mask_bus_oe ? mask_bus_out : mb;
  assign status_bus_in = status_bus_oe ? status_bus_out : sb;
  assign rd_got = vector_oe ? {5'h0, vector_out} : status_bus_oe ? {5'h0, status_bus_out}
                : mask_bus_out;
  vpi_slice u_vpi_slice (.sys_clk, .rst_n, .int_in_n, .latch_bypass, .micro_op_field,
    .instr_enable_n, .mask_bus_in, .mask_bus_out, .mask_bus_oe, .status_bus_in,
    .status_bus_out, .status_bus_oe, .vector_out, .vector_oe, .int_request,
    .interrupt_disable_n, .group_enable_in, .group_advance_receive, .status_overflow_n,
    .cascade_out);
  vpi_ctl_model u_vpi_ctl_model (.status_overflow_n, .interrupt_disable_n, .group_enable_in,
    .group_advance_receive, .parallel_disable_n(cascade_out.parallel_disable_n),
    .lower_groups_disable_n());
  always #25 sys_clk = ~sys_clk;
  // ****************
  // Helpers
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cmp_rd(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t read %h want %h", $time, g, e);
    end
  endtask
  task automatic cmp_bit(input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t flag %b want %b", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic op(input vpi_op_t c, input logic [7:0] d);
    @(negedge sys_clk);
    instr_enable_n = 1'b0;
    micro_op_field = c;
    mb = d;
    sb = d[2:0];
  endtask
  task automatic rd(input vpi_op_t c, input logic [7:0] e);
    q.push_back(e);
    op(c, 8'h00);
  endtask
  task automatic idle();
    @(negedge sys_clk);
    instr_enable_n = 1'b1;
  endtask
  task automatic pulse(input logic [7:0] v);
    @(negedge sys_clk);
    int_in_n = ~v;
    @(negedge sys_clk);
    int_in_n = 8'hff;
  endtask
  task automatic wait_req(input logic e);
    int i;
    for (i = 0; i < 10 && int_request !== e; i++) @(negedge sys_clk);
    if (i == 10) begin
      fails++;
      $display("[ERR] %0t request wait ran out", $time);
      close_out();
    end else begin
      cmp_bit(e, int_request);
    end
  endtask
  // Reads are judged where the enable shows, against the oldest note
  always @(posedge sys_clk) begin
    if (rst_n && (vector_oe | status_bus_oe | mask_bus_oe) !== 1'b0) begin
      cmp_rd(q.size() > 0 ? q.pop_front() : 8'hxx, rd_got);
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    rd(VPI_OP_RD_MASK, VPI_MASK_RST);
    rd(VPI_OP_RD_STAT, 8'h00);
    op(VPI_OP_MCLR, 8'h00);
    idle();
    cmp_bit(1'b0, cascade_out.group_signal_out);
    seed = lfsr(seed);
    m = seed[7:0];
    op(VPI_OP_LD_MASK, m);
    rd(VPI_OP_RD_MASK, m);
    seed = lfsr(seed);
    op(VPI_OP_BSET_MASK, seed[7:0]);
    rd(VPI_OP_RD_MASK, m | seed[7:0]);
    op(VPI_OP_BCLR_MASK, seed[15:8]);
    rd(VPI_OP_RD_MASK, (m | seed[7:0]) & ~seed[15:8]);
    op(VPI_OP_SET_MASK, 8'h00);
    rd(VPI_OP_RD_MASK, VPI_MASK_ALL);
    op(VPI_OP_CLR_MREG, 8'h00);
    idle();
    @(negedge sys_clk) micro_op_field = VPI_OP_SET_MASK;
    rd(VPI_OP_RD_MASK, 8'h00);
    idle();
    pulse(8'h24);
    wait_req(1'b1);
    rd(VPI_OP_RD_VEC, 8'h05);
    rd(VPI_OP_RD_STAT, 8'h06);
    idle();
    wait_req(1'b0);
    op(VPI_OP_CLR_LAST, 8'h00);
    op(VPI_OP_LD_STAT, 8'h00);
    idle();
    wait_req(1'b1);
    rd(VPI_OP_RD_VEC, 8'h02);
    op(VPI_OP_CLR_MBUS, 8'h04);
    op(VPI_OP_LD_STAT, 8'h00);
    idle();
    wait_req(1'b0);
    op(VPI_OP_LD_MASK, 8'h08);
    idle();
    pulse(8'h08);
    repeat (5) @(negedge sys_clk);
    cmp_bit(1'b0, int_request);
    op(VPI_OP_CLR_MREG, 8'h00);
    idle();
    wait_req(1'b1);
    op(VPI_OP_DIS_REQ, 8'h00);
    idle();
    wait_req(1'b0);
    op(VPI_OP_EN_REQ, 8'h00);
    idle();
    wait_req(1'b1);
    op(VPI_OP_CLR_ALL, 8'h00);
    idle();
    wait_req(1'b0);
    pulse(8'h80);
    wait_req(1'b1);
    rd(VPI_OP_RD_VEC, 8'h07);
    rd(VPI_OP_RD_STAT, 8'h00);
    idle();
    cmp_bit(1'b0, status_overflow_n);
    cmp_bit(1'b0, int_request);
    cmp_bit(1'b0, cascade_out.ripple_disable_n);
    op(VPI_OP_MCLR, 8'h00);
    idle();
    cmp_bit(1'b1, status_overflow_n);
    latch_bypass = 1'b1;
    pulse(8'h40);
    wait_req(1'b1);
    rd(VPI_OP_RD_VEC, 8'h06);
    op(VPI_OP_CLR_LAST, 8'h00);
    op(VPI_OP_LD_STAT, 8'h00);
    idle();
    wait_req(1'b0);
    cmp_rd(8'h00, 8'(q.size()));
    close_out();
  end
endmodule
`default_nettype wire
